// file: src/gd_defs.svh
// timing constants, field positions and reset values of the gate driver protection logic
`ifndef GD_DEFS_SVH
`define GD_DEFS_SVH

// functional clock period in ns
`define GD_CLK_PERIOD_NS        8

// printed times, in ns (plain defaults, no figure is given for them)
`define GD_INPUT_MIN_PULSE_NS   40
`define GD_SENSE_GLITCH_NS      200
`define GD_FIXED_MASK_NS        400
`define GD_CLEAR_MIN_NS         1000
`define GD_SLOW_LIMIT_NS        5000
`define GD_TRIP_TO_OFF_NS       16
`define GD_TRIP_TO_FLAG_NS      16

// least times round up to whole cycles
`define GD_INPUT_MIN_CYC  ((`GD_INPUT_MIN_PULSE_NS + `GD_CLK_PERIOD_NS - 1) / `GD_CLK_PERIOD_NS)
`define GD_SENSE_GLITCH_CYC ((`GD_SENSE_GLITCH_NS + `GD_CLK_PERIOD_NS - 1) / `GD_CLK_PERIOD_NS)
`define GD_FIXED_MASK_CYC ((`GD_FIXED_MASK_NS + `GD_CLK_PERIOD_NS - 1) / `GD_CLK_PERIOD_NS)
`define GD_CLEAR_MIN_CYC  ((`GD_CLEAR_MIN_NS + `GD_CLK_PERIOD_NS - 1) / `GD_CLK_PERIOD_NS)
// longest times round down
`define GD_SLOW_LIMIT_CYC     (`GD_SLOW_LIMIT_NS / `GD_CLK_PERIOD_NS)
`define GD_TRIP_TO_OFF_CYC    (`GD_TRIP_TO_OFF_NS / `GD_CLK_PERIOD_NS)
`define GD_TRIP_TO_FLAG_CYC   (`GD_TRIP_TO_FLAG_NS / `GD_CLK_PERIOD_NS)

// bit positions of the synchroniser vectors
`define GD_IDX_POS      0
`define GD_IDX_NEG      1
`define GD_IDX_CLR      2
`define GD_IDX_GLOW     3
`define GD_IDX_TRIP     4

// reset values of the input filters (pulls: drive_neg and clear high)
`define GD_RST_SYNC     5'h06
`define GD_RST_FILT_POS 1'b0
`define GD_RST_FILT_NEG 1'b1
`define GD_RST_FILT_CLR 1'b1

`endif

// file: src/gd_pkg.sv
// types shared by the gate driver protection logic
package gd_pkg;

	// counter word of every timer
	typedef logic [15:0] gd_cnt_t;

	// protection states, gray coded along run -> slow -> safe
	typedef enum logic [1:0] {
		GD_RUN  = 2'h0,
		GD_SLOW = 2'h1,
		GD_SAFE = 2'h3
	} gd_state_e;

	// raw logic inputs and comparator outputs
	typedef struct packed {
		logic sense_trip;   // sense above sense_trip_threshold
		logic gate_low;     // gate below gate_low_threshold
		logic clear_n;      // fault clear / shutdown, active low
		logic drive_neg;    // inverting drive input
		logic drive_pos;    // non-inverting drive input
	} gd_in_s;

	// one deglitch filter: filtered level and run length
	typedef struct packed {
		logic    filt;
		gd_cnt_t cnt;
	} gd_dg_s;

	// driver-side outputs
	typedef struct packed {
		logic gate;         // gate_drive level
		logic gate_oe;      // gate_drive actively driven
		logic miller;       // miller sink switch on
		logic discharge;    // sense-pin discharge switch on
		logic slow_sink;    // slow_shutdown sink switch on
		logic flag_n;       // overcurrent_flag_n level
		logic flag_oe;      // open-drain flag pin pulling low
	} gd_out_s;

	// complete state of the block
	typedef struct packed {
		logic [4:0] sync1;  // first synchroniser stage
		logic [4:0] sync2;  // second synchroniser stage
		gd_dg_s     dg_pos;
		gd_dg_s     dg_neg;
		gd_dg_s     dg_clr;
		gd_dg_s     dg_trip;
		gd_cnt_t    mask_cnt;
		gd_cnt_t    clr_cnt;
		gd_cnt_t    lim_cnt;
		gd_state_e  state;
		gd_out_s    out;
	} gd_state_s;

endpackage

// file: src/gd_protect.sv
// gate driver control and protection logic: deglitch, interlock, miller clamp, saturation trip
//
// Functional notes
// - pulses shorter than input_min_pulse are ignored
// - both drive inputs active forces gate low
// - gate high: miller sink off, comparator ignored
// - gate low: miller sink on below threshold
// - miller sink latched until next turn-on
// - trip turns gate off, enters safe state
// - trip drives overcurrent_flag_n low promptly
// - gate low keeps discharge switch on
// - each turn-on masks saturation protection
// - fixed mask keeps discharge on, then releases
// - sense pulses shorter than glitch window ignored
// - fault latched until clear held low long enough
// - slow variant: trip floats gate, sink on
// - gate low ends slow shutdown, drive low
// - truth table of clear and drive inputs
// - safe state forces outputs to negative rail
// - slow shutdown limit forces gate low
`timescale 1ns/10ps
`include "gd_defs.svh"

module gd_protect #(
	parameter int INPUT_MIN_CYC   = `GD_INPUT_MIN_CYC,    // input_min_pulse in cycles
	parameter int SENSE_GLITCH_CYC = `GD_SENSE_GLITCH_CYC, // sense_glitch_window in cycles
	parameter int FIXED_MASK_CYC  = `GD_FIXED_MASK_CYC,   // fixed_mask_interval in cycles
	parameter int CLEAR_MIN_CYC   = `GD_CLEAR_MIN_CYC,    // clear minimum low time
	parameter int SLOW_LIMIT_CYC  = `GD_SLOW_LIMIT_CYC,   // slow_shutdown_limit in cycles
	parameter bit SLOW_VARIANT    = 1'b1                  // 1: slow-shutdown variant
) (
	// clock and reset
	input  wire logic clock_in,
	input  wire logic rst_n_in,
	// control side inputs
	input  wire logic drive_pos_in,
	input  wire logic drive_neg_in,
	input  wire logic fault_clear_n_in,
	// driver side comparators
	input  wire logic gate_low_cmp_in,
	input  wire logic sense_trip_cmp_in,
	// gate drive pin
	output logic      gate_drive_out,
	output logic      gate_drive_oe_out,
	// sink switches
	output logic      miller_sink_out,
	output logic      sense_discharge_out,
	output logic      slow_shutdown_out,
	// open-drain overcurrent flag
	output logic      overcurrent_flag_n_out,
	output logic      overcurrent_flag_oe_out
);

	gd_pkg::gd_state_s s_r;     // registered state
	gd_pkg::gd_state_s s_nxt;   // next state
	gd_pkg::gd_in_s    raw;     // raw inputs bundled

	// bundle the raw inputs
	assign raw = '{sense_trip: sense_trip_cmp_in, gate_low: gate_low_cmp_in,
		clear_n: fault_clear_n_in, drive_neg: drive_neg_in, drive_pos: drive_pos_in};

	// one step of a symmetric deglitch filter; a level change is taken only
	// after it has stood for limit cycles, so shorter pulses of either sign vanish
	function automatic gd_pkg::gd_dg_s dg_step(input logic in_lvl,
			input gd_pkg::gd_dg_s cur, input gd_pkg::gd_cnt_t limit);
		gd_pkg::gd_dg_s res;
		res = cur;
		if (in_lvl == cur.filt) begin
			res.cnt = '0;
		end else if (cur.cnt + 16'h0001 >= limit) begin
			res.filt = in_lvl;
			res.cnt  = '0;
		end else begin
			res.cnt = cur.cnt + 16'h0001;
		end
		return res;
	endfunction

	// reset image: safe levels, gate held low, flag released
	function automatic gd_pkg::gd_state_s rst_image();
		gd_pkg::gd_state_s r;
		r                 = '0;
		r.sync1           = `GD_RST_SYNC;
		r.sync2           = `GD_RST_SYNC;
		r.dg_pos.filt     = `GD_RST_FILT_POS;
		r.dg_neg.filt     = `GD_RST_FILT_NEG;
		r.dg_clr.filt     = `GD_RST_FILT_CLR;
		r.state           = gd_pkg::GD_RUN;
		r.out.gate_oe     = 1'b1;
		r.out.miller      = 1'b1;
		r.out.discharge   = 1'b1;
		r.out.flag_n      = 1'b1;
		return r;
	endfunction

	// next-state logic
	always_comb begin
		logic cmd_high;     // truth-table result
		logic trip_now;     // confirmed trip while armed
		logic clr_done;     // clear held low long enough
		s_nxt    = s_r;
		cmd_high = 1'b0;
		trip_now = 1'b0;
		clr_done = 1'b0;

		// synchronisers: stage one is read only by stage two
		s_nxt.sync1 = raw;
		s_nxt.sync2 = s_r.sync1;

		// deglitch the control inputs and the sense comparator
		s_nxt.dg_pos = dg_step(s_r.sync2[`GD_IDX_POS], s_r.dg_pos,
			gd_pkg::gd_cnt_t'(INPUT_MIN_CYC));
		s_nxt.dg_neg = dg_step(s_r.sync2[`GD_IDX_NEG], s_r.dg_neg,
			gd_pkg::gd_cnt_t'(INPUT_MIN_CYC));
		s_nxt.dg_clr = dg_step(s_r.sync2[`GD_IDX_CLR], s_r.dg_clr,
			gd_pkg::gd_cnt_t'(INPUT_MIN_CYC));
		s_nxt.dg_trip = dg_step(s_r.sync2[`GD_IDX_TRIP], s_r.dg_trip,
			gd_pkg::gd_cnt_t'(SENSE_GLITCH_CYC));

		// truth table with interlock: both inputs active gives low
		cmd_high = s_r.dg_clr.filt & s_r.dg_pos.filt & ~s_r.dg_neg.filt;

		// clear timer counts filtered low time, saturating at the minimum
		if (s_r.dg_clr.filt) begin
			s_nxt.clr_cnt = '0;
		end else if (s_r.clr_cnt < gd_pkg::gd_cnt_t'(CLEAR_MIN_CYC)) begin
			s_nxt.clr_cnt = s_r.clr_cnt + 16'h0001;
		end
		clr_done = (s_r.clr_cnt >= gd_pkg::gd_cnt_t'(CLEAR_MIN_CYC));

		// armed only when gate is high and the fixed mask has run out;
		// the rest of blanking is the external capacitor charging up
		trip_now = s_r.out.gate & ~s_r.out.discharge & s_r.dg_trip.filt;

		case (s_r.state)
			// normal operation
			gd_pkg::GD_RUN: begin
				if (trip_now) begin
					s_nxt.out.flag_n = 1'b0;
					s_nxt.out.flag_oe = 1'b1;
					s_nxt.out.gate   = 1'b0;
					s_nxt.mask_cnt   = '0;
					if (SLOW_VARIANT) begin
						s_nxt.state         = gd_pkg::GD_SLOW;
						s_nxt.out.gate_oe   = 1'b0;
						s_nxt.out.slow_sink = 1'b1;
						s_nxt.out.miller    = 1'b0;
						s_nxt.out.discharge = 1'b0;
						s_nxt.lim_cnt       = '0;
					end else begin
						s_nxt.state         = gd_pkg::GD_SAFE;
						s_nxt.out.gate_oe   = 1'b1;
						s_nxt.out.miller    = 1'b1;
						s_nxt.out.discharge = 1'b1;
					end
				end else begin
					s_nxt.out.gate    = cmd_high;
					s_nxt.out.gate_oe = 1'b1;
					if (cmd_high) begin
						// turn-on releases the clamp without looking at the gate
						s_nxt.out.miller = 1'b0;
						if (!s_r.out.gate) begin
							// fresh turn-on restarts the fixed mask
							s_nxt.mask_cnt      = gd_pkg::gd_cnt_t'(FIXED_MASK_CYC);
							s_nxt.out.discharge = 1'b1;
						end else if (s_r.mask_cnt > 16'h0001) begin
							s_nxt.mask_cnt = s_r.mask_cnt - 16'h0001;
						end else begin
							s_nxt.mask_cnt      = '0;
							s_nxt.out.discharge = 1'b0;
						end
					end else begin
						s_nxt.mask_cnt      = '0;
						s_nxt.out.discharge = 1'b1;
						// watch the gate only once it is low, latch the clamp once below;
						// a stale comparator level from the high phase must not count
						if (!s_r.out.gate && s_r.sync2[`GD_IDX_GLOW]) begin
							s_nxt.out.miller = 1'b1;
						end
					end
				end
			end
			// slow shutdown: gate floats, sink pulls it down through a resistor
			gd_pkg::GD_SLOW: begin
				s_nxt.lim_cnt = s_r.lim_cnt + 16'h0001;
				if (s_r.sync2[`GD_IDX_GLOW] ||
						s_r.lim_cnt + 16'h0001 >= gd_pkg::gd_cnt_t'(SLOW_LIMIT_CYC)) begin
					s_nxt.state         = gd_pkg::GD_SAFE;
					s_nxt.out.slow_sink = 1'b0;
					s_nxt.out.gate      = 1'b0;
					s_nxt.out.gate_oe   = 1'b1;
					s_nxt.out.miller    = 1'b1;
					s_nxt.out.discharge = 1'b1;
				end
			end
			// latched fault: outputs held to the rail whatever the inputs do
			gd_pkg::GD_SAFE: begin
				s_nxt.out.gate      = 1'b0;
				s_nxt.out.gate_oe   = 1'b1;
				s_nxt.out.miller    = 1'b1;
				s_nxt.out.discharge = 1'b1;
				if (clr_done) begin
					s_nxt.state      = gd_pkg::GD_RUN;
					s_nxt.out.flag_n = 1'b1;
					s_nxt.out.flag_oe = 1'b0;
				end
			end
			// unreachable encodings fall back to the safe state
			default: begin
				s_nxt.state = gd_pkg::GD_SAFE;
			end
		endcase
	end

	// single register of the whole state, synchronous reset
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			s_r <= rst_image();
		end else begin
			s_r <= s_nxt;
		end
	end

	// every output is a flip-flop of the state
	assign gate_drive_out          = s_r.out.gate;
	assign gate_drive_oe_out       = s_r.out.gate_oe;
	assign miller_sink_out         = s_r.out.miller;
	assign sense_discharge_out     = s_r.out.discharge;
	assign slow_shutdown_out       = s_r.out.slow_sink;
	assign overcurrent_flag_n_out  = s_r.out.flag_n;
	// open drain: own flip-flop, pulling low while the fault is latched
	assign overcurrent_flag_oe_out = s_r.out.flag_oe;

endmodule

// file: verif/gd_stage_model.sv
// power stage model: gate level seen by the gate-low comparator
`timescale 1ns/10ps
module gd_stage_model (
	// clock
	input  wire logic clock_in,
	// driver pins
	input  wire logic gate_in,
	input  wire logic oe_in,
	input  wire logic sink_in,
	// 1: slow sink discharges the floating gate, 0: floating gate never falls
	input  wire logic prompt_in,
	// comparator
	output logic      gate_low_out
);
	int n = 0; // cycles with the gate pin floating
	initial gate_low_out = 1'b1;
	// driven gate follows in one cycle, floating gate only via the sink
	always @(posedge clock_in) begin
		n <= oe_in ? 0 : n + 1;
		if (oe_in)
			gate_low_out <= !gate_in;
		else if (sink_in && prompt_in && n > 3)
			gate_low_out <= 1'b1;
	end
endmodule

// file: verif/gd_protect_asserts.sv
// port assertions of the gate driver protection logic
`timescale 1ns/10ps
module gd_protect_asserts (
	// clock and reset
	input wire logic clock_in,
	input wire logic rst_n_in,
	// inputs
	input wire logic drive_pos_in,
	input wire logic drive_neg_in,
	input wire logic fault_clear_n_in,
	input wire logic gate_low_cmp_in,
	input wire logic sense_trip_cmp_in,
	// outputs
	input wire logic gate_drive_out,
	input wire logic gate_drive_oe_out,
	input wire logic miller_sink_out,
	input wire logic sense_discharge_out,
	input wire logic slow_shutdown_out,
	input wire logic overcurrent_flag_n_out
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (!rst_n_in);
	// counts assume a fixed mask of 6 cycles and a glitch window of 4
	sequence mask_s;
		sense_discharge_out [*6] ##1 (!sense_discharge_out || !gate_drive_out);
	endsequence
	// armed trip held past the glitch window
	sequence trip_s;
		(sense_trip_cmp_in && gate_drive_out && !sense_discharge_out) ##1 sense_trip_cmp_in [*6];
	endsequence
	interlock_low_a: assert property ((drive_pos_in && drive_neg_in) [*8] |-> !gate_drive_out)
		else $error("gate high with both drive inputs");
	clear_low_a: assert property (!fault_clear_n_in [*8] |-> !gate_drive_out)
		else $error("gate high with clear low");
	miller_off_a: assert property (gate_drive_out |-> !miller_sink_out)
		else $error("miller sink on while gate high");
	discharge_on_a: assert property (gate_drive_oe_out && !gate_drive_out |-> sense_discharge_out)
		else $error("discharge off while gate low");
	blank_mask_a: assert property ($rose(gate_drive_out) |-> mask_s)
		else $error("fixed mask length wrong");
	trip_off_a: assert property (trip_s |-> ##[1:3] (!overcurrent_flag_n_out && !gate_drive_out))
		else $error("trip not acted on");
	glitch_ignore_a: assert property (overcurrent_flag_n_out && !sense_trip_cmp_in ##1
		sense_trip_cmp_in [*3] ##1 !sense_trip_cmp_in [*6] |-> overcurrent_flag_n_out)
		else $error("short sense pulse tripped");
	fault_latch_a: assert property ($rose(overcurrent_flag_n_out) |-> !$past(fault_clear_n_in, 8))
		else $error("flag released without clear");
	slow_entry_a: assert property ($fell(overcurrent_flag_n_out) |->
		!gate_drive_oe_out && slow_shutdown_out && !gate_drive_out)
		else $error("slow shutdown not entered");
	slow_exit_a: assert property ((slow_shutdown_out && gate_low_cmp_in) [*3] |-> ##[0:2]
		(!slow_shutdown_out && gate_drive_oe_out && !gate_drive_out && miller_sink_out))
		else $error("slow shutdown not ended");
endmodule
bind gd_protect gd_protect_asserts i_chk (.clock_in, .rst_n_in, .drive_pos_in, .drive_neg_in,
	.fault_clear_n_in, .gate_low_cmp_in, .sense_trip_cmp_in, .gate_drive_out, .gate_drive_oe_out,
	.miller_sink_out, .sense_discharge_out, .slow_shutdown_out, .overcurrent_flag_n_out);

// file: verif/tb.sv
// self-checking bench of the gate driver protection logic
`timescale 1ns/10ps
module tb;
	logic       clock_in = 1'b0;
	logic       rst_n_in = 1'b0;
	logic       pos = 1'b0, neg = 1'b1, clr = 1'b1, trip = 1'b0, prompt = 1'b1;
	wire logic  gate, oe, miller, dis, slow, flag_n, flag_oe, glow;
	wire logic [2:0] obs = {slow, flag_n, gate}; // polled outputs
	int         error_cnt = 0;
	int         check_count = 0;
	int         cycles = 0;
	int         seed = 61194;
	int         n;
	logic [2:0] v;
	localparam logic [3:0] ON = 4'hA, OFF = 4'h2; // {pos, neg, clr, trip}
	// small timer values keep the run short; the checker counts assume them too
	localparam int T_IN = 3, T_GL = 4, T_MASK = 6, T_CLR = 6, T_LIM = 20;
	gd_protect #(.INPUT_MIN_CYC(T_IN), .SENSE_GLITCH_CYC(T_GL), .FIXED_MASK_CYC(T_MASK),
		.CLEAR_MIN_CYC(T_CLR), .SLOW_LIMIT_CYC(T_LIM)) i_dut (
		.clock_in, .rst_n_in, .drive_pos_in(pos), .drive_neg_in(neg),
		.fault_clear_n_in(clr), .gate_low_cmp_in(glow), .sense_trip_cmp_in(trip),
		.gate_drive_out(gate), .gate_drive_oe_out(oe), .miller_sink_out(miller),
		.sense_discharge_out(dis), .slow_shutdown_out(slow),
		.overcurrent_flag_n_out(flag_n), .overcurrent_flag_oe_out(flag_oe));
	gd_stage_model i_stage (.clock_in, .gate_in(gate), .oe_in(oe), .sink_in(slow),
		.prompt_in(prompt), .gate_low_out(glow));
	always #4 clock_in = ~clock_in;
	// hang guard, far above the planned run
	always @(posedge clock_in) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			error_cnt++;
			close_out();
		end
	end
	task automatic close_out();
		$display("checks=%0d errors=%0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// inputs change at the falling edge, then hold k cycles
	task automatic set_in(input logic [3:0] p, input int k);
		@(negedge clock_in);
		{pos, neg, clr, trip} = p;
		repeat (k) @(negedge clock_in);
	endtask
	// bounded wait for obs[s] to reach v, k = cycles waited
	task automatic wait_out(input int s, input logic v, output int k);
		k = 0;
		while (obs[s] !== v && k < 60) begin
			@(negedge clock_in);
			k++;
		end
	endtask
	// gate level from the truth table
	function automatic logic exp_gate(input logic [3:0] p);
		return p[3] & ~p[2] & p[1];
	endfunction
	initial begin
		repeat (8) @(negedge clock_in);
		rst_n_in = 1'b1;
		// every drive code first, then random ones
		for (int i = 0; i < 40; i++) begin
			v = (i < 8) ? 3'(i) : 3'($random(seed));
			set_in({v, 1'b0}, 14);
			chk(gate, exp_gate({v, 1'b0}));
			chk(miller, !exp_gate({v, 1'b0}));
			chk(dis, !exp_gate({v, 1'b0}));
		end
		// short input pulses are ignored
		set_in(OFF, 12);
		// a pulse held k cycles stands k+1, so this one lasts T_IN-1 cycles
		set_in(ON, T_IN - 2);
		set_in(OFF, 0);
		wait_out(0, 1'b1, n);
		chk(n, 60);
		set_in(ON, 12);
		set_in(4'h8, T_IN - 2);
		set_in(ON, 0);
		wait_out(0, 1'b0, n);
		chk(n, 60);
		// turn-on: discharge held for the fixed mask
		set_in(OFF, 12);
		set_in(ON, 0);
		wait_out(0, 1'b1, n);
		n = 0;
		while (dis === 1'b1 && n < 20) begin
			@(negedge clock_in);
			n++;
		end
		chk(n, T_MASK);
		set_in(4'hB, T_GL - 2);
		set_in(ON, 12);
		chk(flag_n, 1'b1);
		// trip with the gate falling promptly
		set_in(4'hB, 0);
		wait_out(1, 1'b0, n);
		chk(n, T_GL + 3);
		chk({gate, oe, slow, flag_oe}, 4'h3);
		wait_out(2, 1'b0, n);
		chk({gate, oe, miller, dis}, 4'h7);
		set_in(OFF, 6);
		set_in(ON, 12);
		chk(gate, 1'b0);
		set_in(4'h8, 2);
		set_in(ON, 20);
		chk(flag_n, 1'b0);
		set_in(4'h8, T_IN + T_CLR + 5);
		chk({flag_n, gate, flag_oe}, 3'h4);
		set_in(ON, 12);
		chk(gate, 1'b1);
		// trip with a stuck gate ends at the slow shutdown limit
		prompt = 1'b0;
		set_in(4'hB, 0);
		wait_out(2, 1'b1, n);
		n = 0;
		while (slow === 1'b1 && n < 60) begin
			@(negedge clock_in);
			n++;
		end
		chk(n, T_LIM);
		chk({gate, oe}, 2'h1);
		close_out();
	end
endmodule
